// ---- dac_pkg.sv ----
// Shared constants and carriers for the dual serial-load converter logic
// Assumes inclusion before every design file of the block
package dac_pkg;
    localparam int WIDE_BITS = 16;
    localparam int ADDR_BITS = 2;
    localparam logic [1:0] ADDR_NONE = 2'h0;
    localparam logic [1:0] ADDR_A = 2'h1;
    localparam logic [1:0] ADDR_B = 2'h2;
    localparam logic [1:0] ADDR_BOTH = 2'h3;
    localparam logic [15:0] MID_WIDE = 16'h8000;
    localparam logic [13:0] MID_NARROW = 14'h2000;
    localparam int FIFO_DEPTH = 32;
    localparam int SYNC_STAGES = 3;

    typedef enum logic [1:0] {
        LINK_IDLE = 2'b00,
        LINK_SHIFT = 2'b01,
        LINK_COMMIT = 2'b11
    } link_state_t;

    typedef struct packed {
        logic [1:0] addr;
        logic [15:0] code;
    } frame_t;

    typedef struct packed {
        logic sel_n;
        logic sclk;
        logic sdata;
    } link_pins_t;
endpackage

// ---- frame_fifo.sv ----
// Parameterised FIFO holding received frames
// Assumes one clock domain and synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module frame_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 32
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_q;
    logic [AW:0] rd_q;
    logic [AW:0] level;
    wire push;
    wire pop;

    assign level = wr_q - rd_q;
    assign in_ready = (level != (AW + 1)'(DEPTH));
    assign out_valid = (level != '0);
    assign push = clk_en && in_valid && in_ready;
    assign pop = clk_en && out_valid && out_ready;
    assign out_data = mem[rd_q[AW-1:0]];

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wr_q[AW-1:0]] <= in_data;
        end
    end
endmodule
`default_nettype wire

// ---- dual_dac_serial_load_logic.sv ----
// Serial front end, input and output registers of a dual converter
// Assumes link pins, load strobe and clear arrive asynchronously
`timescale 1ns/1ps
`default_nettype none
module dual_dac_serial_load_logic
    import dac_pkg::*;
#(
    parameter int CODE_BITS = WIDE_BITS
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic sel_n,
    input wire logic serial_in,
    input wire logic sclk,
    input wire logic output_load_n,
    input wire logic clear_n,
    input wire logic midscale,
    output logic [CODE_BITS-1:0] code_a,
    output logic [CODE_BITS-1:0] code_b,
    output logic [CODE_BITS-1:0] input_a,
    output logic [CODE_BITS-1:0] input_b,
    output logic frame_pending
);
    localparam int FRAME_BITS = CODE_BITS + ADDR_BITS;

    // Three-stage synchronisers; stage 1 feeds only stage 2
    logic [SYNC_STAGES-1:0] s_sel_q;
    logic [SYNC_STAGES-1:0] s_clk_q;
    logic [SYNC_STAGES-1:0] s_dat_q;
    logic [SYNC_STAGES-1:0] s_ld_q;
    logic [SYNC_STAGES-1:0] s_clr_q;
    logic [SYNC_STAGES-1:0] s_ms_q;
    logic sel_f_q;
    logic clk_f_q;
    logic ld_f_q;
    logic clr_f_q;
    logic ms_f_q;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s_sel_q <= '1;
            s_clk_q <= '0;
            s_dat_q <= '0;
            s_ld_q <= '1;
            s_clr_q <= '1;
            s_ms_q <= '0;
        end else if (clk_en) begin
            s_sel_q <= {s_sel_q[1:0], sel_n};
            s_clk_q <= {s_clk_q[1:0], sclk};
            s_dat_q <= {s_dat_q[1:0], serial_in};
            s_ld_q <= {s_ld_q[1:0], output_load_n};
            s_clr_q <= {s_clr_q[1:0], clear_n};
            s_ms_q <= {s_ms_q[1:0], midscale};
        end
    end

    // Filtered levels: a change counts once stages two and three agree
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sel_f_q <= 1'b1;
            clk_f_q <= 1'b0;
            ld_f_q <= 1'b1;
            clr_f_q <= 1'b1;
            ms_f_q <= 1'b0;
        end else if (clk_en) begin
            if (s_sel_q[1] == s_sel_q[2]) sel_f_q <= s_sel_q[2];
            if (s_clk_q[1] == s_clk_q[2]) clk_f_q <= s_clk_q[2];
            if (s_ld_q[1] == s_ld_q[2]) ld_f_q <= s_ld_q[2];
            if (s_clr_q[1] == s_clr_q[2]) clr_f_q <= s_clr_q[2];
            if (s_ms_q[1] == s_ms_q[2]) ms_f_q <= s_ms_q[2];
        end
    end

    wire clk_rise = (s_clk_q[1] == s_clk_q[2]) && s_clk_q[2] && !clk_f_q;
    wire sel_rise = (s_sel_q[1] == s_sel_q[2]) && s_sel_q[2] && !sel_f_q;
    wire clr_act = !clr_f_q;
    wire ld_act = !ld_f_q;

    // Clear value chosen by strap and variant
    wire [CODE_BITS-1:0] mid_code = (CODE_BITS == WIDE_BITS) ?
        CODE_BITS'(MID_WIDE) : CODE_BITS'(MID_NARROW);
    wire [CODE_BITS-1:0] clr_code = ms_f_q ? mid_code : '0;

    // Link state machine and shift register
    link_state_t st_q;
    link_state_t st_d;
    logic [FRAME_BITS-1:0] shift_reg_q;
    wire do_shift = (st_q == LINK_SHIFT) && clk_rise && !clr_act &&
        !ld_act;
    wire do_commit = (st_q == LINK_SHIFT) && sel_rise &&
        !clk_f_q;

    always_comb begin
        st_d = st_q;
        case (st_q)
            LINK_IDLE: if (!sel_f_q) st_d = LINK_SHIFT;
            LINK_SHIFT: if (sel_rise) st_d = LINK_COMMIT;
            LINK_COMMIT: st_d = LINK_IDLE;
            default: st_d = LINK_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st_q <= LINK_IDLE;
            shift_reg_q <= '0;
        end else if (clk_en) begin
            st_q <= st_d;
            if (do_shift) begin
                shift_reg_q <= {shift_reg_q[FRAME_BITS-2:0],
                    s_dat_q[2]};
            end
        end
    end

    // Committed frames queue before the input registers
    logic fifo_ready;
    logic fifo_valid;
    logic [FRAME_BITS-1:0] fifo_data;
    frame_fifo #(.WIDTH(FRAME_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .in_valid(do_commit),
        .in_ready(fifo_ready),
        .in_data(shift_reg_q),
        .out_valid(fifo_valid),
        .out_ready(1'b1),
        .out_data(fifo_data)
    );

    wire [1:0] f_addr = fifo_data[FRAME_BITS-1 -: ADDR_BITS];
    wire [CODE_BITS-1:0] f_code = fifo_data[CODE_BITS-1:0];
    wire hit_a = fifo_valid &&
        (f_addr == ADDR_A || f_addr == ADDR_BOTH);
    wire hit_b = fifo_valid &&
        (f_addr == ADDR_B || f_addr == ADDR_BOTH);

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            input_a <= '0;
            input_b <= '0;
            code_a <= '0;
            code_b <= '0;
        end else if (clk_en) begin
            if (clr_act) begin
                input_a <= clr_code;
                input_b <= clr_code;
                code_a <= clr_code;
                code_b <= clr_code;
            end else begin
                if (hit_a) input_a <= f_code;
                if (hit_b) input_b <= f_code;
                if (ld_act) begin
                    code_a <= input_a;
                    code_b <= input_b;
                end
            end
        end
    end

    assign frame_pending = fifo_valid || !fifo_ready;

    property p_shift;
        @(posedge sys_clk) disable iff (!rst_n)
        (clk_en && do_shift) |=> shift_reg_q[0] == $past(s_dat_q[2]);
    endproperty
    a_shift: assert property (p_shift) else $error("shift bit lost");

    property p_hold;
        @(posedge sys_clk) disable iff (!rst_n)
        (clk_en && !do_shift) |=> $stable(shift_reg_q);
    endproperty
    a_hold: assert property (p_hold) else $error("shift moved");

    property p_clear;
        @(posedge sys_clk) disable iff (!rst_n)
        (clk_en && clr_act) |=> code_a == $past(clr_code) &&
            input_b == $past(clr_code);
    endproperty
    a_clear: assert property (p_clear) else $error("clear missed");

    property p_latch;
        @(posedge sys_clk) disable iff (!rst_n)
        (clk_en && !ld_act && !clr_act) |=> $stable(code_a) && $stable(code_b);
    endproperty
    a_latch: assert property (p_latch) else $error("output moved");

    property p_transp;
        @(posedge sys_clk) disable iff (!rst_n)
        (clk_en && ld_act && !clr_act) |=> code_a == $past(input_a) &&
            code_b == $past(input_b);
    endproperty
    a_transp: assert property (p_transp) else $error("no follow");

    property p_none;
        @(posedge sys_clk) disable iff (!rst_n)
        (clk_en && fifo_valid && f_addr == ADDR_NONE && !clr_act) |=>
            $stable(input_a) && $stable(input_b);
    endproperty
    a_none: assert property (p_none) else $error("none loaded");

    property p_load_a;
        @(posedge sys_clk) disable iff (!rst_n)
        (clk_en && hit_a && !clr_act) |=> input_a == $past(f_code);
    endproperty
    a_load_a: assert property (p_load_a) else $error("A not loaded");

    property p_mid;
        @(posedge sys_clk) disable iff (!rst_n)
        (clk_en && clr_act && ms_f_q) |=> code_b == mid_code;
    endproperty
    a_mid: assert property (p_mid) else $error("midscale wrong");
endmodule
`default_nettype wire

// ---- link_host.sv ----
// Behavioural host driving the three-wire serial link
// Assumes the sys_clk of the bench; link clock stands still between frames
`timescale 1ns/1ps
`default_nettype none
module link_host #(
    parameter int HALF = 4
) (
    input wire logic sys_clk,
    output logic sel_n,
    output logic sclk,
    output logic serial_in
);
    // Select, data and clock only; nothing comes back
    initial begin
        sel_n = 1'b1;
        sclk = 1'b0;
        serial_in = 1'b0;
    end

    task automatic wait_half();
        repeat (HALF) @(posedge sys_clk);
    endtask

    // Sends the low n bits of bits, MSB first
    task automatic send(input logic [31:0] bits, input int n);
        sel_n <= 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            serial_in <= bits[i];
            wait_half();
            sclk <= 1'b1;
            wait_half();
            sclk <= 1'b0;
        end
        wait_half();
        // Clock held low while select rises
        sel_n <= 1'b1;
        serial_in <= ~serial_in;
        wait_half();
    endtask
endmodule
`default_nettype wire

// ---- dual_dac_serial_load_logic_tb.sv ----
// Self-checking bench for the dual serial-load converter logic
// Assumes the wide variant, plus a narrow one checked on clear, and the link_host model of the far side
`timescale 1ns/1ps
`default_nettype none
module dual_dac_serial_load_logic_tb;
    import dac_pkg::*;
    logic sys_clk, rst_n, output_load_n, clear_n, midscale, clk_en;
    logic sel_n, sclk, serial_in, frame_pending;
    logic [15:0] code_a, code_b, input_a, input_b, ia, ib, oa, ob;
    logic [31:0] seed;
    logic [17:0] sr;
    logic [13:0] n_input_a, n_code_b;
    int err_total, n_compared, cycles;

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    link_host link_host_inst (.sys_clk(sys_clk), .sel_n(sel_n),
        .sclk(sclk), .serial_in(serial_in));

    dual_dac_serial_load_logic #(.CODE_BITS(16))
        dual_dac_serial_load_logic_inst (.sys_clk(sys_clk), .rst_n(rst_n),
        .clk_en(clk_en), .sel_n(sel_n), .serial_in(serial_in), .sclk(sclk),
        .output_load_n(output_load_n), .clear_n(clear_n),
        .midscale(midscale), .code_a(code_a), .code_b(code_b),
        .input_a(input_a), .input_b(input_b), .frame_pending(frame_pending));

    dual_dac_serial_load_logic #(.CODE_BITS(14))
        narrow_dual_dac_serial_load_logic_inst (.sys_clk(sys_clk),
        .rst_n(rst_n), .clk_en(clk_en), .sel_n(sel_n),
        .serial_in(serial_in), .sclk(sclk), .output_load_n(output_load_n),
        .clear_n(clear_n), .midscale(midscale), .code_a(),
        .code_b(n_code_b), .input_a(n_input_a), .input_b(),
        .frame_pending());

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction

    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask

    task automatic chk_all();
        chk(input_a, ia);
        chk(input_b, ib);
        chk(code_a, oa);
        chk(code_b, ob);
        chk(16'(frame_pending), 16'h0000);
    endtask

    // One frame with extra leading bits, then model update and compare
    task automatic frame(input logic [1:0] addr, input int extra);
        logic [15:0] code;
        seed = xs(seed);
        code = seed[15:0];
        link_host_inst.send({seed[31:18], addr, code}, 18 + extra);
        // Shifting only counts while load and clear are idle
        if (clear_n && output_load_n)
            sr = {addr, code};
        if (clear_n) begin
            if (sr[16]) ia = sr[15:0];
            if (sr[17]) ib = sr[15:0];
            if (!output_load_n) begin
                oa = ia;
                ob = ib;
            end
        end
        repeat (8) @(posedge sys_clk);
        chk_all();
    endtask

    task automatic clr(input logic m);
        clear_n <= 1'b0;
        midscale <= m;
        output_load_n <= 1'b0;
        repeat (6) @(posedge sys_clk);
        ia = m ? MID_WIDE : 16'h0000;
        ib = ia;
        oa = ia;
        ob = ia;
        chk_all();
        chk(16'(n_input_a), m ? 16'(MID_NARROW) : 16'h0000);
        frame(ADDR_BOTH, 0);
        clear_n <= 1'b1;
        output_load_n <= 1'b1;
        repeat (6) @(posedge sys_clk);
        chk_all();
        chk(16'(n_code_b), m ? 16'(MID_NARROW) : 16'h0000);
    endtask

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 12000) begin
            err_total++;
            end_sim();
        end
    end

    initial begin
        rst_n = 1'b0;
        output_load_n = 1'b1;
        clear_n = 1'b1;
        clk_en = 1'b1;
        midscale = 1'b0;
        seed = 32'h0000_0013;
        {ia, ib, oa, ob} = '0;
        sr = '0;
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (5) @(posedge sys_clk);
        chk_all();
        for (int a = 0; a < 4; a++)
            frame(2'(a), 3 * a);
        // Frozen block must ignore a clear
        clk_en <= 1'b0;
        clear_n <= 1'b0;
        repeat (6) @(posedge sys_clk);
        chk_all();
        clear_n <= 1'b1;
        clk_en <= 1'b1;
        output_load_n <= 1'b0;
        repeat (6) @(posedge sys_clk);
        oa = ia;
        ob = ib;
        chk_all();
        frame(ADDR_A, 0);
        output_load_n <= 1'b1;
        frame(ADDR_BOTH, 1);
        clr(1'b1);
        clr(1'b0);
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            output_load_n <= seed[2];
            repeat (6) @(posedge sys_clk);
            if (!output_load_n) begin
                oa = ia;
                ob = ib;
            end
            frame(seed[1:0], int'(seed[5:3]));
        end
        end_sim();
    end
endmodule
`default_nettype wire
